// *** rtl/pwm_gen_slice.sv ***
// Purpose: Trigger, status, reload, snapshot and output override slice of one PWM generator.
// Assumes: All inputs except i_resetn are synchronous to i_core_clk; zero-wait AHB-Lite slave.
// Notes: Outputs are registered; the pin pair lags its causes by one clock.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pwm_gen_slice (
   input  wire logic                    i_core_clk,
   input  wire logic                    i_resetn,
   input  wire logic                    i_hsel,
   input  wire logic [7:0]              i_haddr,
   input  wire logic [1:0]              i_htrans,
   input  wire logic                    i_hwrite,
   input  wire logic [2:0]              i_hsize,
   input  wire logic [31:0]             i_hwdata,
   input  wire logic                    i_hready,
   output logic      [31:0]             o_hrdata,
   output logic                         o_hreadyout,
   output logic                         o_hresp,
   input  wire logic                    i_end_of_cycle,
   input  wire logic [2:0]              i_compare_evt,
   input  wire logic [3:0]              i_group_trig,
   input  wire pwm_slice_pkg::prot_in_t i_prot_act,
   input  wire logic                    i_sync_enable,
   input  wire logic                    i_module_enable,
   input  wire logic                    i_snapshot_evt,
   input  wire logic [15:0]             i_timebase,
   input  wire pwm_slice_pkg::pin_pair_t i_gen_out,
   input  wire logic                    i_push_pull,
   input  wire logic                    i_second_cycle,
   input  wire logic                    i_center_aligned,
   input  wire logic                    i_second_half,
   input  wire logic                    i_debug_halt,
   output pwm_slice_pkg::pin_pair_t     o_pins,
   output logic                         o_cycle_start,
   output logic                         o_cycle_active,
   output logic                         o_trigger_out,
   output logic                         o_reload_strobe,
   output logic      [15:0]             o_active_data
);
   import pwm_slice_pkg::*;

   logic        rst_meta_q;
   logic        rst_sync_q;
   logic        rst_n;
   logic        wr_q;
   logic        rd_sel_q;
   logic [7:0]  addr_q;
   logic [15:0] cfg_q;
   logic [15:0] ov_q;
   logic [15:0] user_data_q;
   logic [15:0] snapshot_q;
   logic [3:0]  evt_q;
   logic [3:0]  prot_prev_q;
   logic        snap_flag_q;
   logic        snap_req_q;
   logic        pending_q;
   logic        alternate_phase_flag_q;
   logic        half_q;
   logic [3:0]  ov_eff_q;
   logic [15:0] wdata;
   logic        wr_cfg;
   logic        wr_stat;
   logic        wr_ov;
   logic        soft_start;
   logic        soft_stop;
   logic        reload_req;
   logic        hw_trig;
   logic        trig_in;
   logic        start_ok;
   logic        apply_reload;
   logic        snap_take;
   logic        ov_load;
   logic [3:0]  prot_vec;
   logic [3:0]  evt_set;
   logic [15:0] status;
   logic [31:0] rd_mux;
   logic        own_trig;
   pin_pair_t   sel;
   pin_pair_t   routed;

   // Reset release through two flip-flops.
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Address phase capture; writes complete in the following data phase.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q     <= 1'b0;
         rd_sel_q <= 1'b0;
         addr_q   <= 8'h00;
      end else begin
         wr_q     <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
         rd_sel_q <= i_hsel && i_htrans[1] && i_hready && !i_hwrite;
         addr_q   <= i_haddr;
      end
   end

   // Register write strobes and one-shot command bits of the status register.
   assign wdata      = i_hwdata[15:0];
   assign wr_cfg     = wr_q && (addr_q == OFS_TRIG_CFG);
   assign wr_stat    = wr_q && (addr_q == OFS_STATUS);
   assign wr_ov      = wr_q && (addr_q == OFS_OVERRIDE);
   assign soft_start = wr_stat && wdata[ST_START];
   assign soft_stop  = wr_stat && wdata[ST_STOP];
   assign reload_req = wr_stat && wdata[ST_RELOAD];

   // Start-of-cycle source selection; peers 1 to 4 are this generator's own group.
   always_comb begin
      hw_trig = 1'b0;
      if (cfg_q[CFG_CYCLE_START_SOURCE_LSB +: 4] == CYCLE_START_SOURCE_LOCAL) begin
         hw_trig = i_end_of_cycle;
      end else if (cfg_q[CFG_CYCLE_START_SOURCE_LSB +: 4] <= CYCLE_START_SOURCE_PEER4) begin
         hw_trig = i_group_trig[cfg_q[CFG_CYCLE_START_SOURCE_LSB +: 2] - 2'd1];
      end
   end
   // Codes above 0100 select no hardware trigger.
   assign trig_in  = hw_trig || (i_sync_enable && i_prot_act.sync) || soft_start;
   assign start_ok = trig_in && (!o_cycle_active || cfg_q[CFG_RETRIG] || i_end_of_cycle);

   // Cycle run state; a stop write wins over every start.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_cycle_active <= 1'b0;
         o_cycle_start  <= 1'b0;
      end else begin
         o_cycle_start <= start_ok && !soft_stop;
         if (soft_stop) begin
            o_cycle_active <= 1'b0;
         end else if (start_ok) begin
            o_cycle_active <= 1'b1;
         end else if (i_end_of_cycle) begin
            o_cycle_active <= 1'b0;
         end
      end
   end

   // Own trigger output choice handed to the other generators of the group.
   always_comb begin
      case (cfg_q[CFG_TRGOUT_LSB +: 3])
         3'h0:    own_trig = i_end_of_cycle;
         3'h1:    own_trig = i_compare_evt[0];
         3'h2:    own_trig = i_compare_evt[1];
         3'h3:    own_trig = i_compare_evt[2];
         default: own_trig = 1'b0;
      endcase
   end
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_trigger_out <= 1'b0;
      end else begin
         o_trigger_out <= own_trig;
      end
   end

   // Configuration and override registers.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RESET;
         ov_q  <= OV_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_q <= wdata & CFG_WMASK;
         end
         if (wr_ov) begin
            ov_q <= wdata;
         end
      end
   end

   // Reload timing: code RELOAD_NOW applies now, all others at the next cycle start.
   assign apply_reload = pending_q && ((cfg_q[CFG_RELOAD_LSB +: 3] == RELOAD_NOW) || o_cycle_start);

   // Update pending handshake; a new request wins over the clearing apply.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_q       <= 1'b0;
         o_reload_strobe <= 1'b0;
      end else begin
         o_reload_strobe <= apply_reload;
         if (reload_req) begin
            pending_q <= 1'b1;
         end else if (apply_reload) begin
            pending_q <= 1'b0;
         end
      end
   end

   // User and active data; user writes are dropped while an update is pending.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         user_data_q   <= DATA_RESET;
         o_active_data <= DATA_RESET;
      end else begin
         if (wr_q && (addr_q == OFS_USER_DATA) && !pending_q) begin
            user_data_q <= wdata;
         end
         if (apply_reload) begin
            o_active_data <= user_data_q;
         end
      end
   end

   // Snapshot: one capture per flag; software writes 0 to re-arm.
   assign snap_take = (snap_req_q || i_snapshot_evt) && !snap_flag_q;
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_flag_q <= 1'b0;
         snap_req_q  <= 1'b0;
         snapshot_q  <= 16'h0000;
      end else begin
         if (wr_stat && wdata[ST_SNAP] && !snap_flag_q) begin
            snap_req_q <= 1'b1;
         end else if (snap_take || snap_flag_q) begin
            snap_req_q <= 1'b0;
         end
         if (snap_take) begin
            snapshot_q  <= i_timebase;
            snap_flag_q <= 1'b1;
         end else if (wr_stat && !wdata[ST_SNAP]) begin
            snap_flag_q <= 1'b0;
         end
      end
   end

   // Protection event flags: edge or enabled level sets, write 1 clears, set wins.
   assign prot_vec = {i_prot_act.sync, i_prot_act.trip, i_prot_act.limit, i_prot_act.feedforward};
   assign evt_set  = (prot_vec & ~prot_prev_q) | (prot_vec & {4{i_module_enable}});
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_q       <= 4'h0;
         prot_prev_q <= 4'h0;
      end else begin
         prot_prev_q <= prot_vec;
         evt_q       <= evt_set | (evt_q & ~(wr_stat ? wdata[ST_EVT_LSB +: 4] : 4'h0));
      end
   end

   // Steering and half-cycle flags are held low outside their modes.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alternate_phase_flag_q <= 1'b0;
         half_q  <= 1'b0;
      end else begin
         alternate_phase_flag_q <= i_push_pull && i_second_cycle;
         half_q  <= i_center_aligned && i_second_half;
      end
   end

   // Effective force settings, loaded according to the force timing field.
   always_comb begin
      case (force_timing_t'(ov_q[OV_SYNC_LSB +: 2]))
         FORCE_AT_CYCLE: ov_load = o_cycle_start;
         FORCE_NOW:      ov_load = 1'b1;
         FORCE_RELOAD:   ov_load = apply_reload;
         default:        ov_load = 1'b0;
      endcase
   end
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ov_eff_q <= 4'h0;
      end else if (ov_load) begin
         ov_eff_q <= {ov_q[OV_EN_HIGH], ov_q[OV_EN_LOW], ov_q[OV_DAT_LSB +: 2]};
      end
   end

   // Output selection by fixed precedence; forced enables and levels come from the loaded copy.
   always_comb begin
      sel = i_gen_out;
      if (i_debug_halt) begin
         sel = {ov_q[OV_HALT_LSB + 1], ov_q[OV_HALT_LSB]};
      end else if (i_prot_act.trip) begin
         sel = {ov_q[OV_TRIP_LSB + 1], ov_q[OV_TRIP_LSB]};
      end else if (i_prot_act.limit) begin
         if (ov_q[OV_LIMIT_INV]) begin
            sel = ~i_gen_out;
         end else begin
            sel = {ov_q[OV_LIMIT_LSB + 1], ov_q[OV_LIMIT_LSB]};
         end
      end else if (i_prot_act.feedforward) begin
         sel = {ov_q[OV_FF_LSB + 1], ov_q[OV_FF_LSB]};
      end else begin
         if (ov_eff_q[3]) begin
            sel.high = ov_eff_q[1];
         end
         if (ov_eff_q[2]) begin
            sel.low = ov_eff_q[0];
         end
      end
      routed = ov_q[OV_SWAP] ? {sel.low, sel.high} : sel;
   end

   // Pin drive after swap and polarity.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_pins <= '0;
      end else begin
         o_pins <= routed ^ {cfg_q[CFG_POL_HIGH], cfg_q[CFG_POL_LOW]};
      end
   end

   // Status word; start, stop and reload command bits read back as zero, the snapshot bit reads its flag.
   assign status = {evt_q, prot_vec, 2'b00, snap_flag_q, pending_q, 1'b0, alternate_phase_flag_q, half_q,
                    o_cycle_active};

   // Read data mux; unmapped offsets read zero.
   always_comb begin
      case (i_haddr)
         OFS_TRIG_CFG:  rd_mux = {16'h0000, cfg_q};
         OFS_STATUS:    rd_mux = {16'h0000, status};
         OFS_OVERRIDE:  rd_mux = {16'h0000, ov_q};
         OFS_SNAPSHOT:  rd_mux = {16'h0000, snapshot_q};
         OFS_USER_DATA: rd_mux = {16'h0000, user_data_q};
         OFS_ACT_DATA:  rd_mux = {16'h0000, o_active_data};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus answer: zero wait states, always OKAY.
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b0;
         o_hresp     <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
            o_hrdata <= rd_mux;
         end else if (!rd_sel_q) begin
            o_hrdata <= 32'h0000_0000;
         end
      end
   end
endmodule // pwm_gen_slice
`default_nettype wire

// *** rtl/pwm_slice_pkg.sv ***
// Purpose: Constants and types for the PWM generator control slice.
// Assumes: AHB-Lite register access, 32-bit data, 16-bit registers in the low half.
// Notes: Register map and field layout, reset values and the selector codes of the slice.
package pwm_slice_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_TRIG_CFG  = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_OVERRIDE  = 8'h08;
   localparam logic [7:0] OFS_SNAPSHOT  = 8'h0C;
   localparam logic [7:0] OFS_USER_DATA = 8'h10;
   localparam logic [7:0] OFS_ACT_DATA  = 8'h14;
   // Trigger configuration fields.
   localparam int CFG_TRGOUT_LSB = 12;
   localparam int CFG_RELOAD_LSB = 8;
   localparam int CFG_RETRIG     = 6;
   localparam int CFG_POL_HIGH   = 5;
   localparam int CFG_POL_LOW    = 4;
   localparam int CFG_CYCLE_START_SOURCE_LSB   = 0;
   localparam logic [15:0] CFG_WMASK = 16'h777F;
   // Status fields.
   localparam int ST_EVT_LSB  = 12;
   localparam int ST_LIVE_LSB = 8;
   localparam int ST_START    = 7;
   localparam int ST_STOP     = 6;
   localparam int ST_SNAP     = 5;
   localparam int ST_PENDING  = 4;
   localparam int ST_RELOAD   = 3;
   localparam int ST_ALTERNATE_PHASE_FLAG    = 2;
   localparam int ST_HALF     = 1;
   localparam int ST_TRIG     = 0;
   // Override register fields.
   localparam int OV_LIMIT_INV = 15;
   localparam int OV_SWAP      = 14;
   localparam int OV_EN_HIGH   = 13;
   localparam int OV_EN_LOW    = 12;
   localparam int OV_DAT_LSB   = 10;
   localparam int OV_SYNC_LSB  = 8;
   localparam int OV_TRIP_LSB  = 6;
   localparam int OV_LIMIT_LSB = 4;
   localparam int OV_FF_LSB    = 2;
   localparam int OV_HALT_LSB  = 0;
   // Reset values.
   localparam logic [15:0] CFG_RESET  = 16'h0000;
   localparam logic [15:0] OV_RESET   = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   // Start-of-cycle source codes.
   localparam logic [3:0] CYCLE_START_SOURCE_LOCAL  = 4'h0;
   localparam logic [3:0] CYCLE_START_SOURCE_PEER1  = 4'h1;
   localparam logic [3:0] CYCLE_START_SOURCE_PEER4  = 4'h4;
   // Force timing codes.
   typedef enum logic [1:0] {
      FORCE_AT_CYCLE = 2'b00,
      FORCE_NOW      = 2'b01,
      FORCE_RELOAD   = 2'b10,
      FORCE_RSVD     = 2'b11
   } force_timing_t;
   // Reload timing codes.
   localparam logic [2:0] RELOAD_AT_CYCLE = 3'h0;
   localparam logic [2:0] RELOAD_NOW      = 3'h1;
   // Pin pair and protection input carriers.
   typedef struct packed {
      logic high;
      logic low;
   } pin_pair_t;
   typedef struct packed {
      logic sync;
      logic trip;
      logic limit;
      logic feedforward;
   } prot_in_t;
endpackage

// *** tb/pwm_slice_properties.sv ***
// Purpose: Port-level checks of trigger, reload and pin behaviour of the PWM slice.
// Assumes: One clock domain; reset active low.
// Notes: Bound to the slice from the bench top.
`timescale 1ns/1ps
`default_nettype none
module pwm_slice_properties
   import pwm_slice_pkg::*;
(
   input wire logic      i_core_clk,
   input wire logic      i_resetn,
   input wire logic      i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic      i_hwrite,
   input wire logic      i_hready,
   input wire logic [31:0] i_hwdata,
   input wire logic      o_hreadyout,
   input wire logic      i_end_of_cycle,
   input wire logic [2:0] i_compare_evt,
   input wire logic [3:0] i_group_trig,
   input wire prot_in_t  i_prot_act,
   input wire logic      i_sync_enable,
   input wire logic      i_debug_halt,
   input wire pin_pair_t o_pins,
   input wire logic      o_cycle_start,
   input wire logic      o_cycle_active,
   input wire logic      o_trigger_out,
   input wire logic      o_reload_strobe,
   input wire logic [15:0] o_active_data
);
   // Causes seen at the inputs.
   wire trig_any = i_end_of_cycle || (|i_group_trig) || (i_sync_enable && i_prot_act.sync);
   wire evt_any  = i_end_of_cycle || (|i_compare_evt);
   wire bus_wr   = i_hsel && i_htrans[1] && i_hready && i_hwrite;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   // An accepted write to the status register.
   sequence s_cmd_write;
      bus_wr && i_haddr == OFS_STATUS;
   endsequence
   a_start_has_cause: assert property (
      o_cycle_start |-> $past(trig_any) || $past(bus_wr, 2) || $past(bus_wr, 3))
      else $error("cycle start without a trigger");
   a_active_from_start: assert property (
      $rose(o_cycle_active) |-> o_cycle_start)
      else $error("trigger status rose without a start");
   a_trig_out_cause: assert property (
      o_trigger_out |-> $past(evt_any))
      else $error("trigger output without an event");
   a_halt_holds_pins: assert property (
      (i_debug_halt && o_hreadyout) [*3] |=> $stable(o_pins))
      else $error("pins moved during debug halt");
   a_reload_after_start: assert property (
      o_reload_strobe |-> $past(o_cycle_start) || $past(bus_wr, 3))
      else $error("reload without a cycle start or a register write");
   a_data_on_reload: assert property (
      $changed(o_active_data) |-> ##[0:2] o_reload_strobe)
      else $error("active data changed outside a reload");
   a_soft_start: assert property (
      s_cmd_write ##1 (i_hwdata[ST_START] && !i_hwdata[ST_STOP]) |-> ##[1:2] o_cycle_active)
      else $error("soft start did not start a cycle");
   a_soft_stop: assert property (
      s_cmd_write ##1 i_hwdata[ST_STOP] |-> ##[1:2] !o_cycle_active)
      else $error("soft stop did not end the cycle");
endmodule // pwm_slice_properties
`default_nettype wire

// *** tb/power_stage_model.sv ***
// Purpose: Gate driver and protection comparator side of the PWM slice.
// Assumes: Protection levels are commanded by the bench.
// Notes: Reports one clock after the command.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model
   import pwm_slice_pkg::*;
(
   input  wire logic      i_core_clk,
   input  wire prot_in_t  i_cmd,
   input  wire pin_pair_t i_pins,
   output var prot_in_t   o_prot,
   output logic           o_shoot
);
   // Comparators run on the core clock so no extra synchroniser is needed.
   always_ff @(posedge i_core_clk) begin
      o_prot <= i_cmd;
   end
   // Both gates on at once marks a shoot-through.
   assign o_shoot = i_pins.high && i_pins.low;
endmodule // power_stage_model
`default_nettype wire

// *** tb/test_pwm_generator_trigger_status_override.sv ***
// Purpose: Self-checking bench of the PWM slice over its register bus and pins.
// Assumes: Zero-wait slave; random values from a fixed seed.
// Notes: Cycle starts and trigger outputs are counted by monitors.
`timescale 1ns/1ps
`default_nettype none
module test_pwm_generator_trigger_status_override;
   import pwm_slice_pkg::*;
   logic        i_core_clk = 1'b0, i_resetn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
   logic [7:0]  i_haddr = 8'h00;
   logic [1:0]  i_htrans = 2'b00;
   logic [2:0]  i_hsize = 3'h2, i_compare_evt = 3'h0;
   logic [31:0] i_hwdata = 32'h0, o_hrdata, rd;
   logic        o_hreadyout, o_hresp, i_end_of_cycle = 1'b0, i_sync_enable = 1'b1, i_module_enable = 1'b0;
   logic        i_snapshot_evt = 1'b0, i_push_pull = 1'b0, i_second_cycle = 1'b0, i_center_aligned = 1'b0;
   logic        i_second_half = 1'b0, i_debug_halt = 1'b0, o_cycle_start, o_cycle_active, o_trigger_out;
   logic        o_reload_strobe, h;
   logic [3:0]  i_group_trig = 4'h0;
   logic [15:0] i_timebase = 16'h0, o_active_data, ov, cfg, t;
   logic [8:0]  ev;
   logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hF};
   logic [7:0]  regs [7] = '{OFS_TRIG_CFG, OFS_STATUS, OFS_OVERRIDE, OFS_SNAPSHOT, OFS_USER_DATA, OFS_ACT_DATA, 8'h20};
   prot_in_t    i_prot_act, prot_cmd = '0, p;
   pin_pair_t   i_gen_out = '0, o_pins, g;
   int          n_mismatch = 0, samples_checked = 0, n_start = 0, n_tout = 0, base;
   wire         i_hready = o_hreadyout;

   pwm_gen_slice DUT (.i_core_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
      .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_end_of_cycle, .i_compare_evt, .i_group_trig,
      .i_prot_act, .i_sync_enable, .i_module_enable, .i_snapshot_evt, .i_timebase, .i_gen_out, .i_push_pull,
      .i_second_cycle, .i_center_aligned, .i_second_half, .i_debug_halt, .o_pins, .o_cycle_start,
      .o_cycle_active, .o_trigger_out, .o_reload_strobe, .o_active_data);
   power_stage_model u_stage (.i_core_clk, .i_cmd(prot_cmd), .i_pins(o_pins), .o_prot(i_prot_act), .o_shoot());

   // Clock and event monitors.
   always #10 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      n_start += int'(o_cycle_start === 1'b1);
      n_tout  += int'(o_trigger_out === 1'b1);
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One single transfer; read data is taken at the data-phase edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      i_hsel   <= 1'b1;
      i_haddr  <= a;
      i_htrans <= 2'b10;
      i_hwrite <= w;
      do @(posedge i_core_clk); while (i_hready !== 1'b1);
      i_hsel   <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= {16'h0000, d};
      do @(posedge i_core_clk); while (i_hready !== 1'b1);
      rd = o_hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      chk({rd[31:16], rd[15:0] & m}, {16'h0000, e});
   endtask
   // Trigger lines: [3:0] peers, [4] end of cycle, [7:5] compares, [8] sync.
   task automatic pulse(input logic [8:0] v);
      i_group_trig   <= v[3:0];
      i_end_of_cycle <= v[4];
      i_compare_evt  <= v[7:5];
      prot_cmd.sync  <= v[8];
      tick(1);
      i_group_trig   <= 4'h0;
      i_end_of_cycle <= 1'b0;
      i_compare_evt  <= 3'h0;
      prot_cmd.sync  <= 1'b0;
      tick(4);
   endtask
   task automatic snap(input logic [15:0] v);
      i_timebase     <= v;
      i_snapshot_evt <= 1'b1;
      tick(1);
      i_snapshot_evt <= 1'b0;
      tick(2);
   endtask
   function automatic logic [8:0] src_vec(input logic [3:0] c);
      if (c == 4'hF) return 9'h100;
      if (c == 4'h0) return 9'h010;
      return (c < 4'h5) ? 9'(1 << (c - 4'h1)) : 9'h001;
   endfunction
   // Starts from two pulses of the selected source: refused while active in single mode, except from the local end of cycle.
   function automatic int exp_starts(input logic [3:0] c, input logic rt);
      if (c > 4'h4 && c != 4'hF) return 0;
      return (rt || c == 4'h0) ? 2 : 1;
   endfunction
   function automatic pin_pair_t exp_pins(input logic [15:0] o, input prot_in_t q, input logic hh,
                                          input pin_pair_t gg, input logic [1:0] pol);
      pin_pair_t v;
      v = {o[13] ? o[11] : gg.high, o[12] ? o[10] : gg.low};
      if (hh) v = o[1:0];
      else if (q.trip) v = o[7:6];
      else if (q.limit) v = o[15] ? ~gg : o[5:4];
      else if (q.feedforward) v = o[3:2];
      if (o[14]) v = {v.low, v.high};
      return v ^ pol;
   endfunction
   task automatic results();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run.
   initial begin
      #400_000;
      n_mismatch++;
      results();
   end

   initial begin
      void'($urandom(32'h46AD));
      tick(8);
      i_resetn <= 1'b1;
      foreach (regs[i]) rchk(regs[i], 16'hFFFF, 16'h0000);
      cfg = 16'($urandom) & 16'hF8FF;
      wr(OFS_TRIG_CFG, cfg);
      wr(8'h20, 16'hFFFF);
      rchk(OFS_TRIG_CFG, 16'hFFFF, cfg & CFG_WMASK);
      rchk(8'h20, 16'hFFFF, 16'h0000);
      // Start sources, single and retrigger modes, soft stop.
      foreach (codes[i]) begin
         wr(OFS_TRIG_CFG, {9'h000, i[0], 2'b00, codes[i]});
         base = n_start;
         pulse(~src_vec(codes[i]) & 9'h01F);
         chk(n_start - base, 0);
         pulse(src_vec(codes[i]));
         pulse(src_vec(codes[i]));
         chk(n_start - base, exp_starts(codes[i], i[0]));
         rchk(OFS_STATUS, 16'h00C9, (exp_starts(codes[i], i[0]) > 0) ? 16'h0001 : 16'h0000);
         wr(OFS_STATUS, 16'h0040);
         tick(3);
         chk({31'h0, o_cycle_active}, 32'h0);
      end
      for (int s = 0; s < 4; s++) begin
         wr(OFS_TRIG_CFG, 16'(s << 12) | 16'h000F);
         base = n_tout;
         ev = 9'(1 << (4 + s));
         pulse(9'h0F0 & ~ev);
         pulse(ev);
         chk(n_tout - base, 1);
      end
      // Output selection with random protection, halt, force and polarity.
      cfg = 16'h000F | (16'($urandom) & 16'h0030);
      wr(OFS_TRIG_CFG, cfg);
      repeat (40) begin
         i_debug_halt <= 1'b0;
         ov = 16'($urandom);
         ov[9:8] = 2'b01;
         p = prot_in_t'(4'($urandom));
         p.sync = 1'b0;
         h = 1'($urandom);
         g = pin_pair_t'(2'($urandom));
         if (ov[15]) begin
            ov[13:12] = 2'b00;
            p.feedforward = 1'b0;
         end
         wr(OFS_OVERRIDE, ov);
         prot_cmd     <= p;
         i_debug_halt <= h;
         i_gen_out    <= g;
         tick(4);
         chk({30'h0, o_pins}, {30'h0, exp_pins(ov, p, h, g, cfg[5:4])});
      end
      // Force timing at cycle start and with reload, plus reload handshake.
      i_debug_halt <= 1'b0;
      prot_cmd     <= '0;
      i_gen_out    <= 2'b01;
      wr(OFS_TRIG_CFG, 16'h000F);
      wr(OFS_OVERRIDE, 16'h0100);
      wr(OFS_OVERRIDE, 16'h3C00);
      tick(3);
      chk({30'h0, o_pins}, 32'h1);
      wr(OFS_STATUS, 16'h0080);
      tick(3);
      chk({30'h0, o_pins}, 32'h3);
      wr(OFS_STATUS, 16'h0040);
      tick(2);
      t = 16'($urandom);
      wr(OFS_USER_DATA, t);
      wr(OFS_OVERRIDE, 16'h3200);
      wr(OFS_STATUS, 16'h0008);
      rchk(OFS_STATUS, 16'h0018, 16'h0010);
      wr(OFS_USER_DATA, ~t);
      rchk(OFS_USER_DATA, 16'hFFFF, t);
      chk({30'h0, o_pins}, 32'h3);
      wr(OFS_STATUS, 16'h0080);
      tick(4);
      chk({30'h0, o_pins}, 32'h0);
      chk({16'h0, o_active_data}, {16'h0, t});
      rchk(OFS_STATUS, 16'h0010, 16'h0000);
      // Immediate reload timing applies a request without a cycle start.
      wr(OFS_TRIG_CFG, 16'h010F);
      wr(OFS_USER_DATA, ~t);
      wr(OFS_STATUS, 16'h0008);
      tick(2);
      chk({16'h0, o_active_data}, {16'h0, ~t});
      wr(OFS_STATUS, 16'h0040);
      // Snapshot request, blocking and release.
      i_timebase <= t;
      wr(OFS_STATUS, 16'h0020);
      tick(2);
      rchk(OFS_STATUS, 16'h0020, 16'h0020);
      snap(~t);
      rchk(OFS_SNAPSHOT, 16'hFFFF, t);
      wr(OFS_STATUS, 16'h0000);
      snap(~t);
      rchk(OFS_SNAPSHOT, 16'hFFFF, ~t);
      // Event flags by edge and by level.
      wr(OFS_STATUS, 16'hF000);
      prot_cmd.trip <= 1'b1;
      tick(1);
      prot_cmd.trip <= 1'b0;
      tick(4);
      rchk(OFS_STATUS, 16'hFF00, 16'h4000);
      wr(OFS_STATUS, 16'h4000);
      rchk(OFS_STATUS, 16'hFF00, 16'h0000);
      i_module_enable <= 1'b1;
      prot_cmd.limit  <= 1'b1;
      tick(4);
      wr(OFS_STATUS, 16'h2000);
      rchk(OFS_STATUS, 16'hFF00, 16'h2200);
      prot_cmd.limit <= 1'b0;
      // Steering and half-cycle flags.
      i_push_pull      <= 1'b1;
      i_center_aligned <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         {i_second_cycle, i_second_half} <= 2'(k);
         tick(2);
         rchk(OFS_STATUS, 16'h0006, 16'(k << 1));
      end
      results();
   end
endmodule // test_pwm_generator_trigger_status_override

bind pwm_gen_slice pwm_slice_properties u_props (.i_core_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans,
   .i_hwrite, .i_hready, .i_hwdata, .o_hreadyout, .i_end_of_cycle, .i_compare_evt, .i_group_trig,
   .i_prot_act, .i_sync_enable, .i_debug_halt, .o_pins, .o_cycle_start, .o_cycle_active, .o_trigger_out,
   .o_reload_strobe, .o_active_data);
`default_nettype wire
